// [rtl/ctc_top.sv]
// tx context: identifier build, vc remap, merge, output state and status
// Behaviour
// - vc in top two identifier bits
// - data type in low six bits
// - csi sources keep their data type
// - raw sources get configured vc and type
// - raw packet edges come from sync lines
// - raw8, raw10, raw12 packings accepted
// - per port raw10 and raw12 identifiers
// - raw vc taken from bits 7:6
// - raw data type taken from bits 5:0
// - two-bit vc, four interleaved streams
// - csi input vc remapped per port
// - both ports merged into one stream
// - pll register selects lane rate
// - auto timing at 800M and 1.6G
// - code 11 selects 400M, rescale timers
// - 1.5G/1.6G options rescale reference timing
// - replicate copies port 0, clock lane
// - sleep select low forces hs-0
// - output enable low gives hi-z
// - inactive with mode 0 and no port disabled gives hi-z
// - mode 1 or disabled gives lp-11
// - active when a mapped port locks
// - pass set while output 0 sends valid data
// - sync status zero unless sync forwarding
// - status readable and routed to gpio
// - types 0x00-0x0f are short packets
`timescale 1ns/1ps
`default_nettype none
`include "ctc_map.svh"

module ctc_top (
    // clocks and reset
    input  wire logic                        clk_i,
    input  wire logic                        link_clk_i,
    input  wire logic                        srst_i,
    // register port
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_port_sel_i,
    output logic      [7:0]                  reg_rdata_o,
    // receive ports
    input  wire ctc_pkg::ctc_rx_t [1:0]      rx_i,
    input  wire logic [1:0]                  rx_lock_i,
    output logic      [1:0]                  rx_ready_o,
    // output state and control
    output var ctc_pkg::ctc_pin_t [1:0]      tx_pin_state_o,
    output logic                             tx_clk1_en_o,
    output logic      [1:0]                  tx_rate_o,
    output logic                             tx_timing_auto_o,
    output logic                             tx_timer_rescale_o,
    output logic                             status_gpio_o,
    output logic                             status_irq_o,
    // link side, on link_clk_i
    output logic      [7:0]                  di_o,
    output logic                             di_short_o,
    output logic                             di_valid_o,
    output logic                             di_rep_valid_o
);
    import ctc_pkg::*;

    function automatic logic [1:0] remap(input logic [7:0] m,
                                         input logic [1:0] v);
        return m[{v, 1'b0} +: 2];
    endfunction

    function automatic logic [7:0] rd_live(input logic [7:0] a,
                                           input logic [7:0] g,
                                           input logic [7:0] pl,
                                           input logic [7:0] f1,
                                           input logic [7:0] f2,
                                           input logic [7:0] st,
                                           input logic [7:0] r10,
                                           input logic [7:0] r12,
                                           input logic [7:0] vm);
        case (a)
            `CTC_OFS_GEN:   return g;
            `CTC_OFS_PLL:   return pl;
            `CTC_OFS_FWD1:  return f1;
            `CTC_OFS_FWD2:  return f2;
            `CTC_OFS_STS:   return st;
            `CTC_OFS_RAW10: return r10;
            `CTC_OFS_RAW12: return r12;
            `CTC_OFS_VCMAP: return vm;
            default:        return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] gen_reg, pll_reg, fwd1_reg, fwd2_reg;
    logic [7:0] raw10_reg [2];
    logic [7:0] raw12_reg [2];
    logic [7:0] vcmap_reg [2];
    logic [7:0] sts_rd;
    logic       pass_reg, sync_reg, chg_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gen_reg  <= `CTC_RST_GEN;
            pll_reg  <= `CTC_RST_PLL;
            fwd1_reg <= `CTC_RST_FWD1;
            fwd2_reg <= `CTC_RST_FWD2;
            for (int p = 0; p < 2; p++) begin
                raw10_reg[p] <= `CTC_RST_RAW10;
                raw12_reg[p] <= `CTC_RST_RAW12;
                vcmap_reg[p] <= `CTC_RST_VCMAP;
            end
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `CTC_OFS_GEN:   gen_reg  <= reg_wdata_i;
                `CTC_OFS_PLL:   pll_reg  <= reg_wdata_i;
                `CTC_OFS_FWD1:  fwd1_reg <= reg_wdata_i;
                `CTC_OFS_FWD2:  fwd2_reg <= reg_wdata_i;
                `CTC_OFS_RAW10: raw10_reg[reg_port_sel_i] <= reg_wdata_i;
                `CTC_OFS_RAW12: raw12_reg[reg_port_sel_i] <= reg_wdata_i;
                `CTC_OFS_VCMAP: vcmap_reg[reg_port_sel_i] <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    assign sts_rd = {5'h00, chg_reg, sync_reg, pass_reg};

    always_ff @(posedge clk_i) begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rd_live(reg_addr_i, gen_reg, pll_reg, fwd1_reg,
                                   fwd2_reg, sts_rd,
                                   raw10_reg[reg_port_sel_i],
                                   raw12_reg[reg_port_sel_i],
                                   vcmap_reg[reg_port_sel_i]);
    end

    // ------------------------------------------------------------
    // lock synchronisers
    // ------------------------------------------------------------
    logic [1:0] lock_s1_reg, lock_s2_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_s1_reg <= 2'h0;
            lock_s2_reg <= 2'h0;
        end else begin
            lock_s1_reg <= rx_lock_i;
            lock_s2_reg <= lock_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // identifier build per receive port
    // ------------------------------------------------------------
    logic [7:0] raw10_sh [2];
    logic [7:0] raw12_sh [2];
    logic [7:0] vcmap_sh [2];
    logic [7:0] cfg_sel  [2];
    logic [7:0] ev_hdr   [2];
    logic [7:0] pend_hdr [2];
    logic [1:0] ev, pend_reg, pend_next, hs_prev_reg, vs_prev_reg;
    logic       busy, take, gp, rr_reg;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // raw8 shares the raw10 identifier
            cfg_sel[p] = (rx_i[p].raw_sel == `CTC_RAW12) ?
                         raw12_sh[p] : raw10_sh[p];
            ev[p]     = 1'b0;
            ev_hdr[p] = 8'h00;
            if (rx_i[p].csi_mode) begin
                ev[p]     = rx_i[p].valid & rx_ready_o[p];
                ev_hdr[p] = {remap(vcmap_sh[p], rx_i[p].vc),
                             rx_i[p].dt};
            end else if (rx_i[p].vsync != vs_prev_reg[p]) begin
                ev[p]     = 1'b1;
                ev_hdr[p] = {cfg_sel[p][7:6],
                             rx_i[p].vsync ? `CTC_DT_FS : `CTC_DT_FE};
            end else if (rx_i[p].hsync && !hs_prev_reg[p]
                         && rx_i[p].vsync) begin
                ev[p]     = 1'b1;
                ev_hdr[p] = {cfg_sel[p][7:6],
                             cfg_sel[p][5:0]};
            end
        end
    end

    // merge: round robin between the two pending headers
    assign take = !busy && (pend_reg != 2'h0);
    assign gp   = pend_reg[rr_reg] ? rr_reg : ~rr_reg;

    always_comb begin
        for (int p = 0; p < 2; p++)
            pend_next[p] = ev[p] |
                           (pend_reg[p] & !(take && gp == p[0]));
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pend_reg    <= 2'h0;
            rx_ready_o  <= 2'h0;
            hs_prev_reg <= 2'h0;
            vs_prev_reg <= 2'h0;
        end else begin
            pend_reg    <= pend_next;
            rx_ready_o  <= ~pend_next;
            for (int p = 0; p < 2; p++) begin
                hs_prev_reg[p] <= rx_i[p].hsync;
                vs_prev_reg[p] <= rx_i[p].vsync;
            end
        end
    end

    // shadows load only while the port holds no packet
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (srst_i) begin
                raw10_sh[p] <= `CTC_RST_RAW10;
                raw12_sh[p] <= `CTC_RST_RAW12;
                vcmap_sh[p] <= `CTC_RST_VCMAP;
                pend_hdr[p] <= 8'h00;
            end else begin
                if (!pend_reg[p] && !ev[p]) begin
                    raw10_sh[p] <= raw10_reg[p];
                    raw12_sh[p] <= raw12_reg[p];
                    vcmap_sh[p] <= vcmap_reg[p];
                end
                if (ev[p])
                    pend_hdr[p] <= ev_hdr[p];
            end
        end
    end

    // ------------------------------------------------------------
    // header handshake into the link domain
    // ------------------------------------------------------------
    logic [7:0] hdr_reg;
    logic       req_tgl_reg, ack_s1_reg, ack_s2_reg, ack_tgl_reg;

    assign busy = req_tgl_reg != ack_s2_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hdr_reg     <= 8'h00;
            req_tgl_reg <= 1'b0;
            rr_reg      <= 1'b0;
            ack_s1_reg  <= 1'b0;
            ack_s2_reg  <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            if (take) begin
                hdr_reg     <= pend_hdr[gp];
                req_tgl_reg <= ~req_tgl_reg;
                rr_reg      <= ~gp;
            end
        end
    end

    logic       lrst_s1_reg, lrst_reg;
    logic       req_s1_reg, req_s2_reg, req_s3_reg;
    logic       rep_s1_reg, rep_s2_reg;

    always_ff @(posedge link_clk_i) begin
        lrst_s1_reg <= srst_i;
        lrst_reg    <= lrst_s1_reg;
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            req_s1_reg     <= 1'b0;
            req_s2_reg     <= 1'b0;
            req_s3_reg     <= 1'b0;
            rep_s1_reg     <= 1'b0;
            rep_s2_reg     <= 1'b0;
            ack_tgl_reg    <= 1'b0;
            di_o           <= 8'h00;
            di_short_o     <= 1'b0;
            di_valid_o     <= 1'b0;
            di_rep_valid_o <= 1'b0;
        end else begin
            req_s1_reg     <= req_tgl_reg;
            req_s2_reg     <= req_s1_reg;
            req_s3_reg     <= req_s2_reg;
            rep_s1_reg     <= fwd2_reg[`CTC_FWD2_REP];
            rep_s2_reg     <= rep_s1_reg;
            ack_tgl_reg    <= req_s2_reg;
            di_valid_o     <= req_s2_reg ^ req_s3_reg;
            di_rep_valid_o <= (req_s2_reg ^ req_s3_reg)
                              & rep_s2_reg;
            if (req_s2_reg ^ req_s3_reg) begin
                di_o       <= hdr_reg;
                di_short_o <= (hdr_reg[5:0] <= `CTC_DT_SHORT_MAX);
            end
        end
    end

    // ------------------------------------------------------------
    // output pin state, rate and status
    // ------------------------------------------------------------
    logic [1:0] fwd_dis, act;
    ctc_pin_t   pin_next [2];
    logic       pass_next, sync_next, rep, err_any;

    assign fwd_dis = fwd1_reg[`CTC_FWD1_DIS0 +: 2];
    assign rep     = fwd2_reg[`CTC_FWD2_REP];

    always_comb begin
        err_any = 1'b0;
        act     = 2'h0;
        for (int p = 0; p < 2; p++) begin
            if (lock_s2_reg[p] && !fwd_dis[p])
                act[fwd1_reg[`CTC_FWD1_SEL0 + p]] = 1'b1;
            err_any = err_any | (rx_i[p].err & !fwd_dis[p]);
        end
        for (int n = 0; n < 2; n++) begin
            if (!gen_reg[`CTC_GEN_SLEEP_SEL])
                pin_next[n] = CTC_PIN_HS0;
            else if (!gen_reg[`CTC_GEN_PIN_EN])
                pin_next[n] = CTC_PIN_HIZ;
            else if (act[n])
                pin_next[n] = CTC_PIN_ACTIVE;
            else if (gen_reg[`CTC_GEN_EN_MODE] || fwd_dis != 2'h0)
                pin_next[n] = CTC_PIN_LP11;
            else
                pin_next[n] = CTC_PIN_HIZ;
        end
        if (rep)
            pin_next[1] = pin_next[0];
        pass_next = act[0] && !err_any
                    && pin_next[0] == CTC_PIN_ACTIVE;
        sync_next = fwd2_reg[`CTC_FWD2_SYNC] && pass_next
                    && lock_s2_reg == 2'h3 && fwd_dis == 2'h0;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_pin_state_o[0]  <= CTC_PIN_HIZ;
            tx_pin_state_o[1]  <= CTC_PIN_HIZ;
            tx_clk1_en_o       <= 1'b0;
            tx_rate_o          <= `CTC_RATE_800;
            tx_timing_auto_o   <= 1'b1;
            tx_timer_rescale_o <= 1'b0;
        end else begin
            tx_pin_state_o[0]  <= pin_next[0];
            tx_pin_state_o[1]  <= pin_next[1];
            tx_clk1_en_o       <= rep | act[1];
            tx_rate_o          <= pll_reg[1:0];
            tx_timing_auto_o   <= !pll_reg[`CTC_PLL_OVERRIDE] &&
                                  (pll_reg[1:0] == `CTC_RATE_800 ||
                                   pll_reg[1:0] == `CTC_RATE_1G6);
            tx_timer_rescale_o <= pll_reg[1:0] != `CTC_RATE_800;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pass_reg      <= 1'b0;
            sync_reg      <= 1'b0;
            chg_reg       <= 1'b0;
            status_gpio_o <= 1'b0;
            status_irq_o  <= 1'b0;
        end else begin
            pass_reg <= pass_next;
            sync_reg <= sync_next;
            // a change in the clearing cycle keeps the flag set
            if (pass_next != pass_reg || sync_next != sync_reg)
                chg_reg <= 1'b1;
            else if (reg_wr_i && reg_addr_i == `CTC_OFS_STS
                     && reg_wdata_i[`CTC_STS_CHG])
                chg_reg <= 1'b0;
            status_gpio_o <= gen_reg[`CTC_GEN_GPIO_SEL] ?
                             sync_reg : pass_reg;
            status_irq_o  <= chg_reg;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_hs0_forced: assert property (!gen_reg[`CTC_GEN_SLEEP_SEL] |=>
        tx_pin_state_o[0] == CTC_PIN_HS0)
        else $error("sleep select low without hs-0");
    a_hiz_pin_off: assert property (
        gen_reg[`CTC_GEN_SLEEP_SEL:0] == 2'h2 |=>
        tx_pin_state_o[0] == CTC_PIN_HIZ)
        else $error("output enable low without hi-z");
    a_inactive_hiz: assert property (
        gen_reg[2:0] == 3'h3 && fwd_dis == 2'h0 && lock_s2_reg == 2'h0
        |=> tx_pin_state_o == {CTC_PIN_HIZ, CTC_PIN_HIZ})
        else $error("inactive outputs not hi-z");
    a_inactive_lp11: assert property (
        gen_reg[2:0] == 3'h7 && lock_s2_reg == 2'h0
        |=> tx_pin_state_o[0] == CTC_PIN_LP11)
        else $error("inactive outputs not lp-11");
    a_sync_off_zero: assert property (
        !fwd2_reg[`CTC_FWD2_SYNC] |=> !sync_reg)
        else $error("sync status set while sync forwarding off");
    a_pass_needs_lock: assert property (
        pass_reg |-> $past(lock_s2_reg) != 2'h0)
        else $error("pass without any lock");
    a_chg_on_edge: assert property (
        $changed(pass_reg) |-> chg_reg ##1 status_irq_o)
        else $error("status change did not raise flag");
    a_rep_mirror: assert property (rep |=>
        tx_pin_state_o[1] == tx_pin_state_o[0] && tx_clk1_en_o)
        else $error("replicate port differs from port 0");
    a_auto_timing: assert property (
        pll_reg == 8'h02 |=> tx_timing_auto_o)
        else $error("auto timing missing at 1.6G");
    a_pend_served: assert property ($rose(pend_reg[0]) |->
        ##[1:40] !pend_reg[0] || rx_ready_o[0])
        else $error("pending header not merged in time");
    a_shadow_hold: assert property (
        pend_reg[0] |=> $stable({vcmap_sh[0], raw10_sh[0], raw12_sh[0]}))
        else $error("identifier config changed inside a packet");
    a_short_type: assert property (@(posedge link_clk_i)
        disable iff (lrst_reg)
        di_valid_o |-> di_short_o == (di_o[5:0] < 6'h10))
        else $error("short packet flag wrong");

    c_raw_line: cover property (ev[0] && !rx_i[0].csi_mode
                                && rx_i[0].hsync);
    c_both_pending: cover property (pend_reg == 2'h3 && take);
    c_rep_active: cover property (rep && act[0]);
    c_chg_clear: cover property (chg_reg ##1 !chg_reg);
endmodule

`default_nettype wire

// [shared/ctc_map.svh]
// register offsets, field positions, reset values and codes of the tx context
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

`define CTC_OFS_GEN        8'h02
`define CTC_OFS_PLL        8'h1f
`define CTC_OFS_FWD1       8'h20
`define CTC_OFS_FWD2       8'h21
`define CTC_OFS_STS        8'h35
`define CTC_OFS_RAW10      8'h70
`define CTC_OFS_RAW12      8'h71
`define CTC_OFS_VCMAP      8'h72

`define CTC_RST_GEN        8'h03
`define CTC_RST_PLL        8'h00
`define CTC_RST_FWD1       8'h00
`define CTC_RST_FWD2       8'h00
`define CTC_RST_RAW10      8'h2b
`define CTC_RST_RAW12      8'h2c
`define CTC_RST_VCMAP      8'he4

`define CTC_GEN_PIN_EN     0
`define CTC_GEN_SLEEP_SEL  1
`define CTC_GEN_EN_MODE    2
`define CTC_GEN_GPIO_SEL   3
`define CTC_PLL_OVERRIDE   7
`define CTC_FWD1_SEL0      0
`define CTC_FWD1_DIS0      4
`define CTC_FWD2_SYNC      1
`define CTC_FWD2_REP       0
`define CTC_STS_PASS       0
`define CTC_STS_SYNC       1
`define CTC_STS_CHG        2

`define CTC_RATE_800       2'h0
`define CTC_RATE_1G5       2'h1
`define CTC_RATE_1G6       2'h2
`define CTC_RATE_400       2'h3

`define CTC_RAW12          2'h2
`define CTC_DT_FS          6'h00
`define CTC_DT_FE          6'h01
`define CTC_DT_SHORT_MAX   6'h0f

`endif

// [shared/ctc_pkg.sv]
// types shared by the tx context block
`default_nettype none

package ctc_pkg;
    typedef struct packed {
        logic       valid;
        logic       csi_mode;
        logic [1:0] raw_sel;
        logic [1:0] vc;
        logic [5:0] dt;
        logic       hsync;
        logic       vsync;
        logic       err;
    } ctc_rx_t;

    typedef enum logic [1:0] {
        CTC_PIN_HS0,
        CTC_PIN_HIZ,
        CTC_PIN_LP11,
        CTC_PIN_ACTIVE
    } ctc_pin_t;
endpackage

`default_nettype wire

// [verif/ctc_csi_sink.sv]
// downstream receiver model: keeps the last header seen on the link
`timescale 1ns/1ps
`default_nettype none

module ctc_csi_sink (
    // link side
    input  wire logic        link_clk_i,
    input  wire logic [7:0]  di_i,
    input  wire logic        di_short_i,
    input  wire logic        di_valid_i,
    input  wire logic        di_rep_valid_i,
    // captured view
    output logic      [7:0]  hdr_o,
    output logic             short_o,
    output logic      [15:0] count_o,
    output logic      [15:0] rep_count_o
);
    initial begin
        hdr_o = 8'h00;
        short_o = 1'b0;
        count_o = 16'h0000;
        rep_count_o = 16'h0000;
    end

    // the receiver takes a header only in the link cycle of its pulse
    always @(posedge link_clk_i) begin
        if (di_valid_i === 1'b1) begin
            hdr_o <= di_i;
            short_o <= di_short_i;
            count_o <= count_o + 16'h0001;
        end
        if (di_rep_valid_i === 1'b1) begin
            rep_count_o <= rep_count_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [verif/test_ctc_top.sv]
// self-checking bench of the tx context block
`timescale 1ns/1ps
`default_nettype none
`include "ctc_map.svh"

module test_ctc_top;
    import ctc_pkg::*;
    logic            clk_i  = 1'b0;
    logic            lclk   = 1'b0;
    logic            srst_i = 1'b1;
    logic            wr     = 1'b0;
    logic            psel   = 1'b0;
    logic [7:0]      addr   = 8'h00;
    logic [7:0]      wdata  = 8'h00;
    logic [1:0]      lock   = 2'b00;
    ctc_rx_t [1:0]   rx     = '0;
    logic [7:0]      rdata, di, s_hdr;
    logic [1:0]      rdy, rate;
    ctc_pin_t [1:0]  pin;
    logic            clk1, tauto, resc, gpio, irq, dsh, dval, drep, s_sh;
    logic [15:0]     s_cnt, s_rep, seen = 16'h0000;
    int              fail_count = 0;
    int              compares = 0;
    logic [7:0]      ofs [9] = '{8'h02, 8'h1f, 8'h20, 8'h21, 8'h35,
                                 8'h70, 8'h71, 8'h72, 8'hff};
    logic [7:0]      rv  [9] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h2b, 8'h2c, 8'he4, 8'h00};

    ctc_top i_ctc_top (.clk_i(clk_i), .link_clk_i(lclk), .srst_i(srst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_port_sel_i(psel), .reg_rdata_o(rdata), .rx_i(rx),
        .rx_lock_i(lock), .rx_ready_o(rdy), .tx_pin_state_o(pin),
        .tx_clk1_en_o(clk1), .tx_rate_o(rate), .tx_timing_auto_o(tauto),
        .tx_timer_rescale_o(resc), .status_gpio_o(gpio),
        .status_irq_o(irq), .di_o(di), .di_short_o(dsh),
        .di_valid_o(dval), .di_rep_valid_o(drep));

    ctc_csi_sink i_ctc_csi_sink (.link_clk_i(lclk), .di_i(di),
        .di_short_i(dsh), .di_valid_i(dval), .di_rep_valid_i(drep),
        .hdr_o(s_hdr), .short_o(s_sh), .count_o(s_cnt),
        .rep_count_o(s_rep));

    initial forever #25 clk_i = ~clk_i;
    initial begin
        #13;
        forever #40 lclk = ~lclk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        addr = a;
        tick(1);
        check(rdata, exp);
    endtask

    task automatic pins(input logic [7:0] g, input logic [7:0] f,
                        input logic [1:0] lk, input ctc_pin_t e0,
                        input ctc_pin_t e1);
        wr_reg(`CTC_OFS_GEN, g);
        wr_reg(`CTC_OFS_FWD1, f);
        lock = lk;
        tick(6);
        check({6'h0, pin[0]}, {6'h0, e0});
        check({6'h0, pin[1]}, {6'h0, e1});
    endtask

    // one header must reach the receiver, and only one
    task automatic wait_hdr(input logic [7:0] exp, input logic sh);
        for (int i = 0; i < 60 && s_cnt == seen; i++) tick(1);
        tick(8);
        check(8'(s_cnt - seen), 8'h01);
        check(s_hdr, exp);
        check({7'h0, s_sh}, {7'h0, sh});
        seen = s_cnt;
    endtask

    task automatic csi(input int p, input logic [1:0] v, input logic [5:0] t);
        tick(1);
        rx[p].valid = 1'b1;
        rx[p].csi_mode = 1'b1;
        rx[p].vc = v;
        rx[p].dt = t;
        for (int i = 0; i < 60 && rdy[p] !== 1'b1; i++) tick(1);
        tick(1);
        check({7'h0, rdy[p]}, 8'h00);
        rx[p].valid = 1'b0;
        rx[p].vc = ~v;
        rx[p].dt = ~t;
    endtask

    task automatic end_of_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        tick(8);
        srst_i = 1'b0;
        foreach (ofs[i]) rd_reg(ofs[i], rv[i]);
        check({6'h0, rdy}, 8'h03);
        psel = 1'b1;
        rd_reg(`CTC_OFS_VCMAP, 8'he4);
        for (int r = 0; r < 4; r++) begin
            wr_reg(`CTC_OFS_PLL, 8'(r));
            tick(2);
            check({6'h0, rate}, 8'(r));
            check({7'h0, tauto}, {7'h0, r == 0 || r == 2});
            check({7'h0, resc}, {7'h0, r != 0});
        end
        wr_reg(`CTC_OFS_PLL, 8'h82);
        tick(2);
        check({7'h0, tauto}, 8'h00);
        pins(8'h03, 8'h00, 2'b00, CTC_PIN_HIZ, CTC_PIN_HIZ);
        pins(8'h01, 8'h00, 2'b00, CTC_PIN_HS0, CTC_PIN_HS0);
        pins(8'h02, 8'h00, 2'b00, CTC_PIN_HIZ, CTC_PIN_HIZ);
        pins(8'h07, 8'h00, 2'b00, CTC_PIN_LP11, CTC_PIN_LP11);
        pins(8'h03, 8'h20, 2'b10, CTC_PIN_LP11, CTC_PIN_LP11);
        pins(8'h03, 8'h02, 2'b10, CTC_PIN_HIZ, CTC_PIN_ACTIVE);
        pins(8'h03, 8'h00, 2'b10, CTC_PIN_ACTIVE, CTC_PIN_HIZ);
        rd_reg(`CTC_OFS_STS, 8'h05);
        check({6'h0, gpio, irq}, 8'h03);
        wr_reg(`CTC_OFS_STS, 8'h04);
        rd_reg(`CTC_OFS_STS, 8'h01);
        check({7'h0, irq}, 8'h00);
        wr_reg(`CTC_OFS_FWD2, 8'h02);
        lock = 2'b11;
        tick(6);
        rd_reg(`CTC_OFS_STS, 8'h07);
        wr_reg(`CTC_OFS_GEN, 8'h0b);
        wr_reg(`CTC_OFS_STS, 8'h04);
        rx[0].err = 1'b1;
        tick(4);
        rd_reg(`CTC_OFS_STS, 8'h04);
        check({7'h0, gpio}, 8'h00);
        rx[0].err = 1'b0;
        wr_reg(`CTC_OFS_FWD2, 8'h00);
        wr_reg(`CTC_OFS_GEN, 8'h03);
        psel = 1'b0;
        csi(0, 2'h1, 6'h2a);
        wait_hdr(8'h6a, 1'b0);
        psel = 1'b1;
        wr_reg(`CTC_OFS_VCMAP, 8'h1b);
        csi(1, 2'h0, 6'h0f);
        wait_hdr(8'hcf, 1'b1);
        csi(1, 2'h2, 6'h10);
        wait_hdr(8'h50, 1'b0);
        csi(0, 2'h3, 6'h12);
        wait_hdr(8'hd2, 1'b0);
        psel = 1'b0;
        wr_reg(`CTC_OFS_RAW10, 8'h6b);
        wr_reg(`CTC_OFS_RAW12, 8'hec);
        rx[0].csi_mode = 1'b0;
        rx[0].raw_sel = 2'h0;
        rx[0].vsync = 1'b1;
        wait_hdr(8'h40, 1'b1);
        rx[0].hsync = 1'b1;
        wait_hdr(8'h6b, 1'b0);
        rx[0].hsync = 1'b0;
        rx[0].raw_sel = `CTC_RAW12;
        tick(2);
        rx[0].hsync = 1'b1;
        wait_hdr(8'hec, 1'b0);
        rx[0].vsync = 1'b0;
        wait_hdr(8'hc1, 1'b1);
        // software keeps the lane count at two or less here
        wr_reg(`CTC_OFS_FWD2, 8'h01);
        tick(3);
        check({7'h0, clk1}, 8'h01);
        check({6'h0, pin[1]}, {6'h0, pin[0]});
        csi(0, 2'h2, 6'h2b);
        wait_hdr(8'hab, 1'b0);
        check(8'(s_rep), 8'h01);
        end_of_test();
    end
endmodule
`default_nettype wire
